// >>> src/sld_segment_lcd_driver.sv
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module sld_segment_lcd_driver
    import sld_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // sub-oscillator clock pin
    input  wire logic              fs_pin,
    // panel drive and booster clock
    output var sld_drive_t         lcd_drive,
    output logic                   booster_clk
);

    ////////////////////////////////////////////////////////////////////////////
    // fs pin synchroniser; only the agreed level counts, first stage feeds stage two only

    logic fs_s1_q;
    logic fs_s2_q;
    logic fs_s3_q;
    logic fs_lvl_q;
    logic fs_tick;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fs_s1_q <= 1'b0;
            fs_s2_q <= 1'b0;
            fs_s3_q <= 1'b0;
        end else begin
            fs_s1_q <= fs_pin;
            fs_s2_q <= fs_s1_q;
            fs_s3_q <= fs_s2_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fs_lvl_q <= 1'b0;
        end else if (fs_s2_q == fs_s3_q) begin
            fs_lvl_q <= fs_s3_q;
        end
    end

    // one-cycle enable per Fs rising edge; all scan timing hangs off it
    assign fs_tick = (fs_s2_q == fs_s3_q) && fs_s3_q && !fs_lvl_q;

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    logic [DATA_W-1:0] control_q;
    logic [RAM_AW-1:0] ram_addr_q;
    logic [1:0]        boost_sel_q;
    logic [3:0]        ram [NUM_SEG];

    logic      bias_third;
    logic      display_en;
    logic      type_b;
    logic [1:0] frame_sel;
    sld_duty_t duty;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control_q <= CONTROL_RESET;
        end else if (reg_wr && reg_addr == OFS_DISPLAY_CONTROL) begin
            control_q <= reg_wdata & CONTROL_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ram_addr_q <= '0;
        end else if (reg_wr && reg_addr == OFS_RAM_ADDRESS) begin
            ram_addr_q <= reg_wdata[RAM_AW-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boost_sel_q <= 2'h0;
        end else if (reg_wr && reg_addr == OFS_BOOSTER_CONTROL) begin
            boost_sel_q <= reg_wdata[BIT_BOOST_HI:BIT_BOOST_LO];
        end
    end

    // display RAM has no reset; software fills it before enabling the display
    always_ff @(posedge ref_clk) begin
        if (reg_wr && reg_addr == OFS_RAM_DATA_BUFFER) begin
            ram[ram_addr_q] <= reg_wdata[3:0];
        end
    end

    assign bias_third = control_q[BIT_BIAS_SELECT];
    assign display_en = control_q[BIT_DISPLAY_EN];
    assign type_b     = control_q[BIT_WAVEFORM_TYPE];
    assign frame_sel  = control_q[BIT_FRAME_HI:BIT_FRAME_LO];

    always_comb begin
        if (control_q[BIT_DUTY_HI]) begin
            duty = SLD_DUTY_QUARTER;
        end else if (control_q[BIT_DUTY_LO]) begin
            duty = SLD_DUTY_THIRD;
        end else begin
            duty = SLD_DUTY_HALF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scan timing

    logic [SLOT_W-1:0] divisor;
    logic [SLOT_W-1:0] slot_len;
    logic [1:0]        last_com;
    logic [SLOT_W-1:0] slot_cnt_q;
    logic [1:0]        com_idx_q;
    logic              half_q;
    logic              pol_q;
    logic              slot_end;
    logic              com_wrap;

    always_comb begin
        case (duty)
            SLD_DUTY_HALF: begin
                divisor  = DIV_DUTY_HALF[frame_sel];
                last_com = 2'h1;
            end
            SLD_DUTY_THIRD: begin
                divisor  = DIV_DUTY_THIRD[frame_sel];
                last_com = 2'h2;
            end
            SLD_DUTY_QUARTER: begin
                divisor  = DIV_DUTY_QUARTER[frame_sel];
                last_com = 2'h3;
            end
            default: begin
                divisor  = DIV_DUTY_QUARTER[frame_sel];
                last_com = 2'h3;
            end
        endcase
    end

    // type A flips polarity every half slot, so each slot lasts divisor ticks either way
    assign slot_len = type_b ? divisor : {1'b0, divisor[SLOT_W-1:1]};
    assign slot_end = fs_tick && (slot_cnt_q >= slot_len - 9'h001);
    // a duty change mid-frame may leave the index past the new end; wrap to 0 at the next advance
    assign com_wrap = (com_idx_q >= last_com);

    // runs from Fs alone, so cpu power modes do not stop the refresh
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot_cnt_q <= '0;
        end else if (!display_en) begin
            slot_cnt_q <= '0;
        end else if (slot_end) begin
            slot_cnt_q <= '0;
        end else if (fs_tick) begin
            slot_cnt_q <= slot_cnt_q + 9'h001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            half_q <= 1'b0;
        end else if (!display_en || type_b) begin
            half_q <= 1'b0;
        end else if (slot_end) begin
            half_q <= !half_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            com_idx_q <= 2'h0;
        end else if (!display_en) begin
            com_idx_q <= 2'h0;
        end else if (slot_end && (type_b || half_q)) begin
            com_idx_q <= com_wrap ? 2'h0 : com_idx_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pol_q <= 1'b0;
        end else if (!display_en) begin
            pol_q <= 1'b0;
        end else if (slot_end && (!type_b || com_wrap)) begin
            pol_q <= !pol_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // level selection

    function automatic logic [LVL_W-1:0] pick_level(
        input logic is_com,
        input logic active,
        input logic pol,
        input logic third
    );
        logic [LVL_W-1:0] lvl;
        lvl = LVL_GND;
        if (is_com) begin
            if (active) begin
                lvl = pol ? LVL_GND : LVL_TOP;
            end else if (third) begin
                lvl = pol ? LVL_HIGH : LVL_LOW;
            end else begin
                lvl = LVL_MID;
            end
        end else begin
            if (active) begin
                lvl = pol ? LVL_TOP : LVL_GND;
            end else if (third) begin
                lvl = pol ? LVL_LOW : LVL_HIGH;
            end else begin
                lvl = pol ? LVL_GND : LVL_TOP;
            end
        end
        return lvl;
    endfunction : pick_level

    sld_drive_t drive_d;
    sld_drive_t drive_q;

    always_comb begin
        drive_d = '0;
        for (int c = 0; c < NUM_COM; c++) begin
            // commons past the duty never select, so they hold the unselected level
            drive_d.com[c] = pick_level(1'b1, com_idx_q == c[1:0], pol_q, bias_third);
        end
        for (int s = 0; s < NUM_SEG; s++) begin
            drive_d.seg[s] = pick_level(1'b0, ram[s][com_idx_q], pol_q, bias_third);
        end
        if (!display_en) begin
            drive_d = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign lcd_drive = drive_q;

    ////////////////////////////////////////////////////////////////////////////
    // booster clock

    logic [3:0] boost_cnt_q;
    logic       boost_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boost_cnt_q <= 4'h0;
        end else if (fs_tick) begin
            boost_cnt_q <= boost_cnt_q + 4'h1;
        end
    end

    // Fs itself is passed as the agreed synchronised level, a few cycles late
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boost_q <= 1'b0;
        end else begin
            case (boost_sel_q)
                2'h0:    boost_q <= fs_lvl_q;
                2'h1:    boost_q <= boost_cnt_q[1];
                2'h2:    boost_q <= boost_cnt_q[2];
                2'h3:    boost_q <= boost_cnt_q[3];
                default: boost_q <= 1'b0;
            endcase
        end
    end

    assign booster_clk = boost_q;

    ////////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe

    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_DISPLAY_CONTROL: rdata_q <= control_q;
                OFS_RAM_ADDRESS:     rdata_q <= {3'h0, ram_addr_q};
                OFS_RAM_DATA_BUFFER: rdata_q <= {4'h0, ram[ram_addr_q]};
                OFS_BOOSTER_CONTROL: rdata_q <= {5'h00, boost_sel_q, 1'b0};
                OFS_SCAN_STATUS:     rdata_q <= {4'h0, pol_q, half_q, com_idx_q};
                default:             rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : sld_segment_lcd_driver

`default_nettype wire

// >>> src/sld_pkg.sv
// Behaviour
// - drive 32 segment and 4 common outputs, up to 128 dots
// - keep refreshing the panel in normal, green and idle power modes
// - derive all display timing from the sub-oscillator clock Fs only
// - control bit 7 picks 1/2 bias when clear, 1/3 bias when set
// - control bits 6:5 pick duty: 00 half, 01 third, 1x quarter
// - control bit 4 enables display; when clear all common and segment outputs sit at ground
// - control bit 2 picks waveform type A when clear, type B when set
// - control bits 1:0 pick frame divisor per duty from the fixed table
// - address register bits 7:5 always read zero
// - 5-bit address picks one RAM entry 00h-1Fh, entry n drives segment n
// - data buffer low nibble moves RAM data, bit n is state during common n
// - booster bits 2:1 pick booster clock Fs, Fs/4, Fs/8, Fs/16
package sld_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DISPLAY_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_RAM_ADDRESS     = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_RAM_DATA_BUFFER = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_BOOSTER_CONTROL = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_SCAN_STATUS     = 3'h4;

    // display_control fields
    localparam int unsigned BIT_BIAS_SELECT   = 7;
    localparam int unsigned BIT_DUTY_HI       = 6;
    localparam int unsigned BIT_DUTY_LO       = 5;
    localparam int unsigned BIT_DISPLAY_EN    = 4;
    localparam int unsigned BIT_WAVEFORM_TYPE = 2;
    localparam int unsigned BIT_FRAME_HI      = 1;
    localparam int unsigned BIT_FRAME_LO      = 0;
    localparam logic [DATA_W-1:0] CONTROL_MASK  = 8'hF7;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;

    // booster fields
    localparam int unsigned BIT_BOOST_HI = 2;
    localparam int unsigned BIT_BOOST_LO = 1;

    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int unsigned NUM_SEG   = 32;
    localparam int unsigned NUM_COM   = 4;
    localparam int unsigned RAM_AW    = 5;
    localparam int unsigned LVL_W     = 2;
    localparam int unsigned SLOT_W    = 9;

    // drive level codes; in 1/2 bias the mid code means half of the top level
    localparam logic [LVL_W-1:0] LVL_GND  = 2'h0;
    localparam logic [LVL_W-1:0] LVL_LOW  = 2'h1;
    localparam logic [LVL_W-1:0] LVL_HIGH = 2'h2;
    localparam logic [LVL_W-1:0] LVL_TOP  = 2'h3;
    localparam logic [LVL_W-1:0] LVL_MID  = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // frame divisors per frame select code 0..3, one table per duty
    localparam logic [3:0][SLOT_W-1:0] DIV_DUTY_HALF    = {9'h0E8, 9'h130, 9'h118, 9'h100};
    localparam logic [3:0][SLOT_W-1:0] DIV_DUTY_THIRD   = {9'h09C, 9'h0CC, 9'h0BC, 9'h0AC};
    localparam logic [3:0][SLOT_W-1:0] DIV_DUTY_QUARTER = {9'h074, 9'h098, 9'h08C, 9'h080};

    typedef enum logic [1:0] {
        SLD_DUTY_HALF    = 2'h0,
        SLD_DUTY_THIRD   = 2'h1,
        SLD_DUTY_QUARTER = 2'h3
    } sld_duty_t;

    typedef struct packed {
        logic [NUM_COM-1:0][LVL_W-1:0] com;
        logic [NUM_SEG-1:0][LVL_W-1:0] seg;
    } sld_drive_t;

endpackage : sld_pkg

// >>> verification/sld_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sld_checker_sva
    import sld_pkg::*;
(
    // clock and register port
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // panel side
    input wire logic              fs_pin,
    input wire sld_drive_t        lcd_drive,
    input wire logic              booster_clk
);
    logic [DATA_W-1:0] ctl_q;
    logic [RAM_AW-1:0] adr_q;
    logic [3:0]        ram_q [NUM_SEG];
    logic [3:0]        age_q;
    int                n_ext;
    logic              bad_lvl;
    wire               on_ok = ctl_q[BIT_DISPLAY_EN] && age_q > 4'h5;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= '0;
            adr_q <= '0;
            age_q <= '0;
        end else begin
            if (reg_wr && reg_addr == OFS_DISPLAY_CONTROL) ctl_q <= reg_wdata & CONTROL_MASK;
            if (reg_wr && reg_addr == OFS_RAM_ADDRESS) adr_q <= reg_wdata[RAM_AW-1:0];
            age_q <= (reg_wr && reg_addr == OFS_DISPLAY_CONTROL) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        end
    end
    // no reset here: only entries that software wrote are worth comparing
    always_ff @(posedge ref_clk) begin
        if (reg_wr && reg_addr == OFS_RAM_DATA_BUFFER) ram_q[adr_q] <= reg_wdata[3:0];
    end
    always_comb begin
        n_ext = 0;
        bad_lvl = 1'b0;
        for (int c = 0; c < NUM_COM; c++) begin
            n_ext += int'(lcd_drive.com[c][1] == lcd_drive.com[c][0]);
            bad_lvl |= lcd_drive.com[c] == LVL_HIGH;
        end
        for (int s = 0; s < NUM_SEG; s++) bad_lvl |= lcd_drive.seg[s][1] != lcd_drive.seg[s][0];
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [ADDR_W-1:0] ofs);
        reg_rd && reg_addr == ofs;
    endsequence
    property p_reset_quiet;
        $fell(rst) |-> lcd_drive == '0 && reg_rdata == '0 && !booster_clk;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    property p_addr_read;
        s_rd(OFS_RAM_ADDRESS) |=> reg_rdata == {3'h0, adr_q};
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("address readback wrong");
    property p_ram_read;
        s_rd(OFS_RAM_DATA_BUFFER) |=> reg_rdata == {4'h0, ram_q[adr_q]};
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("ram readback wrong");
    property p_ctl_read;
        s_rd(OFS_DISPLAY_CONTROL) |=> reg_rdata == ctl_q;
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
    property p_off_ground;
        !ctl_q[BIT_DISPLAY_EN] && age_q > 4'h3 |-> lcd_drive == '0;
    endproperty
    a_off_ground: assert property (p_off_ground) else $error("drive not grounded when off");
    property p_one_selected;
        on_ok |-> n_ext == 1;
    endproperty
    a_one_selected: assert property (p_one_selected) else $error("selected common count wrong");
    property p_half_idle;
        on_ok && ctl_q[6:5] == 2'h0 |-> lcd_drive.com[3][1] != lcd_drive.com[3][0]
            && lcd_drive.com[2][1] != lcd_drive.com[2][0];
    endproperty
    a_half_idle: assert property (p_half_idle) else $error("unused common scanned");
    property p_bias_half;
        on_ok && !ctl_q[BIT_BIAS_SELECT] |-> !bad_lvl;
    endproperty
    a_bias_half: assert property (p_bias_half) else $error("third level seen in half bias");
endmodule : sld_checker_sva
`default_nettype wire

// >>> verification/sld_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module sld_panel_model
    import sld_pkg::*;
(
    // electrodes
    input  wire sld_drive_t   drive,
    // what the glass shows
    output logic [1:0]         sel_idx,
    output logic [LVL_W-1:0]   sel_lvl,
    output logic [NUM_SEG-1:0] lit
);
    // a dot lights only when segment and selected common sit at opposite rails
    always_comb begin
        sel_idx = 2'h0;
        sel_lvl = drive.com[0];
        for (int c = NUM_COM - 1; c >= 0; c--) begin
            if (drive.com[c][1] == drive.com[c][0]) begin
                sel_idx = 2'(c);
                sel_lvl = drive.com[c];
            end
        end
        for (int s = 0; s < NUM_SEG; s++) lit[s] = drive.seg[s] == ~sel_lvl;
    end
endmodule : sld_panel_model
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sld_pkg::*;
    // fs at a quarter of ref_clk keeps a full scan short
    localparam int FS_P = 4;
    logic              ref_clk;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              fs_pin;
    sld_drive_t        lcd_drive;
    logic              booster_clk;
    logic [1:0]        sel_idx;
    logic [LVL_W-1:0]  sel_lvl;
    logic [NUM_SEG-1:0] lit;
    int                error_cnt = 0;
    int                n_compared = 0;

    sld_segment_lcd_driver sld_segment_lcd_driver_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fs_pin(fs_pin),
        .lcd_drive(lcd_drive), .booster_clk(booster_clk));
    sld_panel_model sld_panel_model_i (.drive(lcd_drive), .sel_idx(sel_idx), .sel_lvl(sel_lvl), .lit(lit));
    ////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        fs_pin = 1'b0;
        forever begin
            repeat (FS_P / 2) @(posedge ref_clk);
            fs_pin <= ~fs_pin;
        end
    end
    function automatic logic [3:0] pat(int s);
        return 4'(s * 7 + 3);
    endfunction : pat
    function automatic int div_of(int d, int f);
        int t [3][4] = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
        return t[d][f];
    endfunction : div_of
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk({24'h0, reg_rdata}, {24'h0, exp});
    endtask : rd
    // counts cycles until the selected common (or its level) moves
    task automatic wait_chg(input logic lvl, output int cyc);
        logic [3:0] k0;
        #1;
        k0 = {sel_lvl & {2{lvl}}, sel_idx};
        cyc = 0;
        while ({sel_lvl & {2{lvl}}, sel_idx} === k0 && cyc < 5000) begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
    endtask : wait_chg
    task automatic wait_rise(output int c);
        logic p;
        c = 0;
        do begin
            p = booster_clk;
            @(posedge ref_clk);
            #1;
            c++;
        end while (!(booster_clk && !p) && c < 500);
    endtask : wait_rise
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////
    initial begin
        #5_000_000;
        chk(32'h0, 32'h1);
        give_verdict();
    end
    initial begin
        int cyc;
        int n;
        logic [1:0] prev;
        logic [LVL_W-1:0] lvl0;
        logic [DATA_W-1:0] ctl;
        logic [NUM_SEG-1:0] exp_lit;
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFS_DISPLAY_CONTROL, CONTROL_RESET);
        rd(OFS_SCAN_STATUS, 8'h00);
        for (int a = 5; a < 8; a++) rd(3'(a), 8'h00);
        wr(OFS_DISPLAY_CONTROL, 8'hFF);
        rd(OFS_DISPLAY_CONTROL, 8'hF7);
        wr(OFS_RAM_ADDRESS, 8'hFF);
        rd(OFS_RAM_ADDRESS, 8'h1F);
        wr(OFS_DISPLAY_CONTROL, 8'h00);
        for (int s = 0; s < NUM_SEG; s++) begin
            wr(OFS_RAM_ADDRESS, 8'(s));
            wr(OFS_RAM_DATA_BUFFER, {4'hF, pat(s)});
        end
        for (int s = NUM_SEG - 1; s >= 0; s--) begin
            wr(OFS_RAM_ADDRESS, 8'(s));
            rd(OFS_RAM_DATA_BUFFER, {4'h0, pat(s)});
        end
        $display("test registers done");
        for (int b = 0; b < 4; b++) begin
            wr(OFS_BOOSTER_CONTROL, {5'h1F, 2'(b), 1'b1});
            rd(OFS_BOOSTER_CONTROL, {5'h00, 2'(b), 1'b0});
            wait_rise(cyc);
            wait_rise(cyc);
            chk(cyc, FS_P * (b == 0 ? 1 : 2 ** (b + 1)));
        end
        $display("test booster done");
        for (int d = 0; d < 3; d++) begin
            for (int f = 0; f < 4; f++) begin
                n = d + 2;
                ctl = {f != 1, d == 2 ? {1'b1, f[0]} : 2'(d), 3'h1, 2'(f)};
                wr(OFS_DISPLAY_CONTROL, ctl);
                wr(OFS_DISPLAY_CONTROL, ctl | 8'h10);
                wait_chg(1'b0, cyc);
                lvl0 = sel_lvl;
                for (int k = 0; k < n; k++) begin
                    prev = sel_idx;
                    wait_chg(1'b0, cyc);
                    chk(cyc, div_of(d, f) * FS_P);
                    chk({30'h0, sel_idx}, (prev + 1) % n);
                    for (int s = 0; s < NUM_SEG; s++) exp_lit[s] = 1'(pat(s) >> sel_idx);
                    chk(lit, exp_lit);
                    chk({30'h0, lcd_drive.com[(sel_idx + 1) % n]},
                        {30'h0, ctl[7] ? (sel_lvl == LVL_TOP ? LVL_LOW : LVL_HIGH) : LVL_MID});
                end
                chk({30'h0, sel_lvl}, {30'h0, ~lvl0});
            end
        end
        wr(OFS_DISPLAY_CONTROL, 8'hC0);
        wr(OFS_DISPLAY_CONTROL, 8'hD0);
        repeat (4) @(posedge ref_clk);
        wait_chg(1'b1, cyc);
        wait_chg(1'b1, cyc);
        chk(cyc, 64 * FS_P);
        wr(OFS_DISPLAY_CONTROL, 8'hC4);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({31'h0, lcd_drive != '0}, 32'h0);
        $display("test scan done");
        give_verdict();
    end
endmodule : tb
bind sld_segment_lcd_driver sld_checker_sva sld_checker_sva_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fs_pin(fs_pin),
    .lcd_drive(lcd_drive), .booster_clk(booster_clk));
`default_nettype wire
